// ---- shared/dftt_pkg.sv ----
// shared constants and types for the diode fault and trip threshold block
package dftt_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] DFTT_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] DFTT_STATUS_ADDR = 8'h04;
  localparam logic [7:0] DFTT_TRIP_ADDR   = 8'h08;
  localparam logic [7:0] DFTT_DATA_BASE   = 8'h0c;
  localparam logic [7:0] DFTT_DATA_LAST   = 8'h28;
  // ==========================================================================
  // control fields
  localparam int DFTT_CTRL_LPM_BIT   = 0;
  localparam int DFTT_CTRL_CHANNEL1_SETTING_OVERRIDE_BIT  = 1;
  localparam int DFTT_CTRL_THERM_LSB = 4;
  localparam logic [3:0] DFTT_THERM_RESET = 4'h0;
  // status fields
  localparam int DFTT_ST_FAULT_BIT = 0;
  localparam int DFTT_ST_HWFS_BIT  = 1;
  localparam int DFTT_ST_TRIP_BIT  = 2;
  localparam int DFTT_ST_MON_BIT   = 3;
  // ==========================================================================
  // data codes
  localparam logic [7:0] DFTT_FAULT_CODE   = 8'h80;
  localparam logic [7:0] DFTT_AP_OPEN_CODE = 8'h7f;
  localparam logic [7:0] DFTT_AP_SHRT_CODE = 8'hc0;
  localparam logic [7:0] DFTT_FULL_SCALE   = 8'hff;
  localparam logic [7:0] DFTT_TRIP_MIN     = 8'h3c;
  localparam logic [7:0] DFTT_FIRST_MARGIN = 8'h0a;
  localparam logic [7:0] DFTT_DATA_RESET   = 8'h00;
  localparam logic [2:0] DFTT_AP_FIRST_CH  = 3'h4;
  // ==========================================================================
  // one converter result as delivered by the scheduler
  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
    logic [7:0] code;
    logic       ovf;
    logic       open;
    logic       shorted;
  } dftt_meas_type;
endpackage : dftt_pkg

// ---- hdl/dftt_core.sv ----
// diode fault reporting, thermistor inversion and setpoint trip logic
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - open or short diode: 80h, fault set
// - anti-parallel open: 7Fh, fault left unchanged
// - anti-parallel short: C0h, fault set
// - thermistor code stored as FFh minus raw
// - thermistor codes compared raw, no conversion
// - drive divider on channel one during measurement in thermistor mode
// - channels two to four selectable diode/thermistor
// - setpoint sampled at first setpoint strobe with monitoring on after reset
// - trip threshold stored by hardware alone
// - trip threshold between 60 and 123
// - open setpoint gives lowest threshold
// - shutdown asserts when channel one exceeds threshold while power good is high
// - channel one mode strapped, changed only with override
// - anti-parallel pair measured with current reversed for the whole conversion
// - overrange input saturates to full scale
// - first cycle trips at threshold minus ten
// - condition clears below threshold
// - monitoring only with power good or low power
module dftt_core
  import dftt_pkg::*;
(
  input  wire logic        clk_sys_i,        // 100 MHz clock
  input  wire logic        rst_i,            // async reset, active high
  input  wire logic        hsel_i,           // ahb select
  input  wire logic [7:0]  haddr_i,          // ahb byte address
  input  wire logic [1:0]  htrans_i,         // ahb transfer type
  input  wire logic        hwrite_i,         // ahb write
  input  wire logic [2:0]  hsize_i,          // ahb size
  input  wire logic [31:0] hwdata_i,         // ahb write data
  input  wire logic        hready_i,         // ahb bus ready
  output logic      [31:0] hrdata_o,         // ahb read data
  output logic             hreadyout_o,      // ahb slave ready
  output logic             hresp_o,          // ahb response
  input  wire logic        power_good_in_i,  // power good pin
  input  wire logic        setpoint_pullup_i, // channel one strap pin
  input  wire logic        conv_busy_i,      // conversion in progress
  input  wire logic [2:0]  conv_chan_i,      // channel being converted
  input  wire dftt_meas_type meas_i,         // converter result
  input  wire logic        setpoint_valid_i, // setpoint result strobe
  input  wire logic [7:0]  trip_setpoint_input_i, // setpoint code
  input  wire logic        setpoint_ovf_i,   // setpoint over range
  input  wire logic        setpoint_open_i,  // setpoint pin open
  input  wire logic        cycle_done_i,     // conversion cycle end
  output logic             monitor_run_o,    // monitoring allowed
  output logic             channel1_drive_pin_o, // divider drive
  output logic             current_reverse_o, // anti-parallel direction
  output logic             hardware_overtemp_flag_n_o, // failsafe, low
  output logic             system_shutdown_out_n_o // shutdown, low
);
  // ==========================================================================
  // helpers
  function automatic logic [7:0] sat_code(input logic [7:0] c, input logic ovf);
    sat_code = ovf ? DFTT_FULL_SCALE : c;
  endfunction : sat_code

  function automatic logic above(input logic [7:0] a, input logic [7:0] b,
                                 input logic raw);
    above = raw ? (a > b) : ($signed(a) > $signed(b));
  endfunction : above

  // ==========================================================================
  // pin synchronisers and strap capture
  logic [1:0] pg_sync;
  logic [1:0] pu_sync;
  logic [1:0] strap_cnt;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pg_sync <= 2'h0;
      pu_sync <= 2'h0;
    end else begin
      pg_sync <= {pg_sync[0], power_good_in_i};
      pu_sync <= {pu_sync[0], setpoint_pullup_i};
    end
  end

  // ==========================================================================
  // control and status registers
  logic       low_power_monitor_enable;
  logic       channel1_setting_override;
  logic [3:0] therm;
  logic       fault;
  logic [7:0] trip_threshold;
  logic       trip_valid;
  logic       first_cycle;
  logic       over;
  logic [7:0] data [0:7];
  logic       mon;
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       addr_ok;
  logic       fault_set;
  logic       fault_clr;
  logic [7:0] meas_val;
  logic       meas_raw;

  assign mon     = pg_sync[1] | low_power_monitor_enable;
  assign addr_ok = hsel_i & htrans_i[1] & hready_i;
  assign fault_clr = wr_pend & (wr_addr == DFTT_STATUS_ADDR) & hwdata_i[DFTT_ST_FAULT_BIT];

  // ahb address phase capture
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok & hwrite_i;
      wr_addr <= haddr_i;
    end
  end

  // read data is prepared at the address phase edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (addr_ok && !hwrite_i) begin
        hrdata_o <= 32'h0;
        if (haddr_i == DFTT_CTRL_ADDR)
          hrdata_o <= {24'h0, therm, 2'h0, channel1_setting_override, low_power_monitor_enable};
        else if (haddr_i == DFTT_STATUS_ADDR)
          hrdata_o <= {28'h0, mon, trip_valid, over, fault};
        else if (haddr_i == DFTT_TRIP_ADDR)
          hrdata_o <= {24'h0, trip_threshold};
        else if (haddr_i >= DFTT_DATA_BASE && haddr_i <= DFTT_DATA_LAST &&
                 haddr_i[1:0] == 2'h0)
          hrdata_o <= {24'h0, data[3'((haddr_i - DFTT_DATA_BASE) >> 2)]};
      end
    end
  end

  // control register; channel one mode from strap unless overridden
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      low_power_monitor_enable       <= 1'b0;
      channel1_setting_override      <= 1'b0;
      therm     <= DFTT_THERM_RESET;
      strap_cnt <= 2'h0;
    end else begin
      if (strap_cnt != 2'h3) begin
        // strap is read only once it has passed both synchroniser stages
        strap_cnt <= strap_cnt + 2'h1;
        if (strap_cnt == 2'h2)
          therm[0] <= pu_sync[1];
      end else if (wr_pend && wr_addr == DFTT_CTRL_ADDR) begin
        low_power_monitor_enable   <= hwdata_i[DFTT_CTRL_LPM_BIT];
        channel1_setting_override  <= hwdata_i[DFTT_CTRL_CHANNEL1_SETTING_OVERRIDE_BIT];
        therm[3:1] <= hwdata_i[DFTT_CTRL_THERM_LSB+1 +: 3];
        if (channel1_setting_override)
          therm[0] <= hwdata_i[DFTT_CTRL_THERM_LSB];
      end
    end
  end

  // ==========================================================================
  // measurement data path
  always_comb begin
    meas_val  = sat_code(meas_i.code, meas_i.ovf);
    fault_set = 1'b0;
    meas_raw  = (meas_i.chan < DFTT_AP_FIRST_CH) && therm[meas_i.chan[1:0]];
    if (meas_raw) begin
      meas_val = DFTT_FULL_SCALE - meas_val;
    end else if (meas_i.chan >= DFTT_AP_FIRST_CH) begin
      if (meas_i.shorted) begin
        meas_val  = DFTT_AP_SHRT_CODE;
        fault_set = 1'b1;
      end else if (meas_i.open) begin
        meas_val = DFTT_AP_OPEN_CODE;
      end
    end else if (meas_i.open || meas_i.shorted) begin
      meas_val  = DFTT_FAULT_CODE;
      fault_set = 1'b1;
    end
    fault_set = fault_set & meas_i.valid;
  end

  // signed degrees pass through unchanged for diodes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++)
        data[i] <= DFTT_DATA_RESET;
    end else if (meas_i.valid) begin
      data[meas_i.chan] <= meas_val;
    end
  end

  // sticky fault, set wins over write-one-to-clear
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      fault <= 1'b0;
    else if (fault_set)
      fault <= 1'b1;
    else if (fault_clr)
      fault <= 1'b0;
  end

  // ==========================================================================
  // pin drive for channel one divider and anti-parallel direction
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      channel1_drive_pin_o <= 1'b0;
      current_reverse_o    <= 1'b0;
      monitor_run_o        <= 1'b0;
    end else begin
      monitor_run_o        <= mon;
      channel1_drive_pin_o <= conv_busy_i && conv_chan_i == 3'h0 && therm[0];
      current_reverse_o    <= conv_busy_i && conv_chan_i >= DFTT_AP_FIRST_CH;
    end
  end

  // ==========================================================================
  // setpoint decode: 256 codes onto 64 degree steps from 60
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trip_threshold <= DFTT_TRIP_MIN;
      trip_valid     <= 1'b0;
    end else if (setpoint_valid_i && mon && !trip_valid) begin
      trip_valid <= 1'b1;
      if (setpoint_open_i)
        trip_threshold <= DFTT_TRIP_MIN;
      else
        trip_threshold <= DFTT_TRIP_MIN +
          (sat_code(trip_setpoint_input_i, setpoint_ovf_i) >> 2);
    end
  end

  // ==========================================================================
  // over-temperature evaluation on channel one
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      first_cycle <= 1'b1;
    else if (cycle_done_i && trip_valid)
      first_cycle <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      over <= 1'b0;
    end else if (mon && trip_valid) begin
      if (first_cycle && cycle_done_i &&
          above(data[0], trip_threshold - DFTT_FIRST_MARGIN, therm[0]))
        over <= 1'b1;
      else if (!first_cycle && meas_i.valid && meas_i.chan == 3'h0) begin
        if (above(meas_val, trip_threshold, therm[0]))
          over <= 1'b1;
        else if (above(trip_threshold, meas_val, therm[0]))
          over <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hardware_overtemp_flag_n_o <= 1'b1;
      system_shutdown_out_n_o    <= 1'b1;
    end else begin
      hardware_overtemp_flag_n_o <= ~over;
      if (pg_sync[1])
        system_shutdown_out_n_o <= ~over;
    end
  end

  // ==========================================================================
  // checks
  AST_FAULT_CODE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    meas_i.valid && meas_i.chan < 3'h4 && !therm[meas_i.chan[1:0]] && meas_i.open
    |=> data[$past(meas_i.chan)] == 8'h80 && fault)
    else $error("fault code not stored");
  AST_AP_OPEN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    meas_i.valid && meas_i.chan >= 3'h4 && meas_i.open && !meas_i.shorted && !fault
    |=> data[$past(meas_i.chan)] == 8'h7f && !fault)
    else $error("anti-parallel open wrong");
  AST_AP_SHORT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    meas_i.valid && meas_i.chan >= 3'h4 && meas_i.shorted
    |=> data[$past(meas_i.chan)] == 8'hc0 && fault)
    else $error("anti-parallel short wrong");
  AST_THERM_INV: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    meas_i.valid && meas_i.chan == 3'h1 && therm[1] && !meas_i.ovf
    |=> data[1] == 8'hff - $past(meas_i.code))
    else $error("thermistor inversion wrong");
  AST_DRIVE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_busy_i && conv_chan_i == 3'h0 && therm[0] |=> channel1_drive_pin_o)
    else $error("divider not driven");
  AST_TRIP_RANGE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    trip_valid |-> trip_threshold >= 8'h3c && trip_threshold <= 8'h7b)
    else $error("trip out of range");
  AST_OPEN_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    setpoint_valid_i && mon && !trip_valid && setpoint_open_i |=> trip_threshold == 8'h3c)
    else $error("open setpoint not minimum");
  AST_SHDN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    over && pg_sync[1] |=> !system_shutdown_out_n_o)
    else $error("shutdown not asserted");
  AST_FAULT_KEEP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fault_set && fault_clr |=> fault)
    else $error("fault lost on clear");
  AST_AP_DIR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_busy_i && conv_chan_i >= 3'h4 |=> current_reverse_o)
    else $error("direction not reversed");
endmodule : dftt_core
`default_nettype wire

// ---- tb/dftt_far_model.sv ----
// far-side model: converter results, setpoint pin and cycle strobe
`timescale 1ns/100ps
`default_nettype none
module dftt_far_model
  import dftt_pkg::*;
(
  input  wire logic    clk_i,     // bench clock
  output dftt_meas_type meas_o,   // converter result
  output logic         busy_o,    // conversion running
  output logic [2:0]   chan_o,    // channel converted
  output logic         sp_vld_o,  // setpoint strobe
  output logic [7:0]   sp_code_o, // setpoint code
  output logic         sp_ovf_o,  // setpoint over range
  output logic         sp_open_o, // setpoint pin open
  output logic         done_o     // cycle end strobe
);
  initial begin
    meas_o = '0;
    busy_o = 1'b0;
    chan_o = 3'h0;
    sp_vld_o = 1'b0;
    sp_code_o = 8'h00;
    sp_ovf_o = 1'b0;
    sp_open_o = 1'b0;
    done_o = 1'b0;
  end
  // ==========================================================================
  // flt is {over range, open, shorted}; released lines show the inverse
  task automatic conv(input logic [2:0] ch, input logic [7:0] cd, input logic [2:0] flt);
    @(posedge clk_i);
    busy_o <= 1'b1;
    chan_o <= ch;
    repeat (3) @(posedge clk_i);
    busy_o <= 1'b0;
    meas_o <= '{1'b1, ch, cd, flt[2], flt[1], flt[0]};
    @(posedge clk_i);
    meas_o <= '{1'b0, ~ch, ~cd, ~flt[2], ~flt[1], ~flt[0]};
  endtask : conv
  task automatic sp(input logic [7:0] cd, input logic ovf, input logic opn);
    @(posedge clk_i);
    sp_vld_o <= 1'b1;
    sp_code_o <= cd;
    sp_ovf_o <= ovf;
    sp_open_o <= opn;
    @(posedge clk_i);
    sp_vld_o <= 1'b0;
    sp_code_o <= ~cd;
    sp_ovf_o <= ~ovf;
    sp_open_o <= ~opn;
  endtask : sp
  task automatic done();
    @(posedge clk_i);
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
  endtask : done
endmodule : dftt_far_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the diode fault and trip threshold block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dftt_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          rst_i     = 1'b1;
  logic          hsel = 1'b0, hwrite = 1'b0, pg = 1'b0, pu = 1'b0;
  logic [7:0]    haddr  = 8'h00;
  logic [1:0]    htrans = 2'h0;
  logic [31:0]   hwdata = 32'h0, hrdata;
  logic          hready, hresp, mon, drv, rev, flag_n, shdn_n, busy, spv, spf, spo, done;
  logic [2:0]    chan;
  logic [7:0]    spc;
  dftt_meas_type meas;
  int            err_total = 0, check_count = 0;
  logic [23:0]   sp_tab [4] = '{24'h00013c, 24'h10027b, 24'hff007b, 24'h500050};
  always #5 clk_sys_i = ~clk_sys_i;
  dftt_core dftt_core_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .power_good_in_i(pg), .setpoint_pullup_i(pu),
    .conv_busy_i(busy), .conv_chan_i(chan), .meas_i(meas), .setpoint_valid_i(spv),
    .trip_setpoint_input_i(spc), .setpoint_ovf_i(spf), .setpoint_open_i(spo),
    .cycle_done_i(done), .monitor_run_o(mon), .channel1_drive_pin_o(drv),
    .current_reverse_o(rev), .hardware_overtemp_flag_n_o(flag_n),
    .system_shutdown_out_n_o(shdn_n));
  dftt_far_model dftt_far_model_inst (.clk_i(clk_sys_i), .meas_o(meas), .busy_o(busy),
    .chan_o(chan), .sp_vld_o(spv), .sp_code_o(spc), .sp_ovf_o(spf), .sp_open_o(spo),
    .done_o(done));
  // ==========================================================================
  // checking and bus tasks
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    rd = hrdata;
    check(hresp, 0);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, d, v);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    check(v, e);
  endtask : rdc
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_cyc
  // ==========================================================================
  // test sequence
  initial begin
    for (int i = 0; i < 4; i++) begin
      rst_i <= 1'b1;
      pu    <= (i == 2);
      wait_cyc(2);
      check({hready, flag_n, shdn_n, mon, drv, rev}, 32'h38);
      @(posedge clk_sys_i);
      rst_i <= 1'b0;
      wait_cyc(4);
      check(mon, 0);
      dftt_far_model_inst.sp(8'hff, 1'b0, 1'b0);
      wr(DFTT_CTRL_ADDR, 32'h1);
      wait_cyc(3);
      check(mon, 1);
      rdc(DFTT_CTRL_ADDR, {24'h0, 3'h0, i == 2, 4'h1});
      dftt_far_model_inst.sp(sp_tab[i][23:16], sp_tab[i][9], sp_tab[i][8]);
      rdc(DFTT_TRIP_ADDR, {24'h0, sp_tab[i][7:0]});
    end
    dftt_far_model_inst.sp(8'h00, 1'b0, 1'b1);
    wr(DFTT_TRIP_ADDR, 32'h11);
    rdc(DFTT_TRIP_ADDR, 32'h50);
    rdc(8'h3c, 32'h0);
    dftt_far_model_inst.conv(3'h1, 8'h19, 3'b010);
    rdc(DFTT_DATA_BASE + 8'h04, 32'h80);
    rdc(DFTT_STATUS_ADDR, 32'hd);
    wr(DFTT_STATUS_ADDR, 32'h1);
    dftt_far_model_inst.conv(3'h5, 8'h19, 3'b010);
    rdc(DFTT_DATA_BASE + 8'h14, 32'h7f);
    rdc(DFTT_STATUS_ADDR, 32'hc);
    dftt_far_model_inst.conv(3'h6, 8'h19, 3'b001);
    rdc(DFTT_DATA_BASE + 8'h18, 32'hc0);
    rdc(DFTT_STATUS_ADDR, 32'hd);
    // clear of the fault flag lands on the same edge as a new short
    fork
      dftt_far_model_inst.conv(3'h3, 8'h19, 3'b001);
      begin
        repeat (2) @(posedge clk_sys_i);
        wr(DFTT_STATUS_ADDR, 32'h1);
      end
    join
    rdc(DFTT_DATA_BASE + 8'h0c, 32'h80);
    rdc(DFTT_STATUS_ADDR, 32'hd);
    wr(DFTT_STATUS_ADDR, 32'h1);
    fork
      dftt_far_model_inst.conv(3'h7, 8'h2a, 3'b000);
      begin
        wait_cyc(3);
        check(rev, 1);
      end
    join
    wait_cyc(1);
    check(rev, 0);
    wr(DFTT_CTRL_ADDR, 32'h21);
    dftt_far_model_inst.conv(3'h1, 8'h30, 3'b000);
    rdc(DFTT_DATA_BASE + 8'h04, 32'hcf);
    dftt_far_model_inst.conv(3'h1, 8'h30, 3'b100);
    rdc(DFTT_DATA_BASE + 8'h04, 32'h00);
    dftt_far_model_inst.conv(3'h2, 8'h30, 3'b000);
    rdc(DFTT_DATA_BASE + 8'h08, 32'h30);
    dftt_far_model_inst.conv(3'h0, 8'h47, 3'b000);
    wait_cyc(3);
    check(flag_n, 1);
    dftt_far_model_inst.done();
    wait_cyc(3);
    check(flag_n, 0);
    dftt_far_model_inst.conv(3'h0, 8'h50, 3'b000);
    wait_cyc(3);
    check(flag_n, 0);
    dftt_far_model_inst.conv(3'h0, 8'h4f, 3'b000);
    wait_cyc(3);
    check(flag_n, 1);
    dftt_far_model_inst.conv(3'h0, 8'h51, 3'b000);
    wait_cyc(3);
    check({flag_n, shdn_n}, 32'h1);
    @(posedge clk_sys_i);
    pg <= 1'b1;
    wait_cyc(5);
    check(shdn_n, 0);
    rdc(DFTT_STATUS_ADDR, 32'he);
    dftt_far_model_inst.conv(3'h0, 8'hc0, 3'b000);
    wait_cyc(3);
    check(flag_n, 1);
    wr(DFTT_CTRL_ADDR, 32'h11);
    rdc(DFTT_CTRL_ADDR, 32'h01);
    wr(DFTT_CTRL_ADDR, 32'h03);
    wr(DFTT_CTRL_ADDR, 32'h13);
    rdc(DFTT_CTRL_ADDR, 32'h13);
    fork
      dftt_far_model_inst.conv(3'h0, 8'h20, 3'b000);
      begin
        wait_cyc(3);
        check(drv, 1);
      end
    join
    wait_cyc(1);
    check(drv, 0);
    rdc(DFTT_DATA_BASE, 32'hdf);
    end_of_test();
  end
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
